//--- hdl/srp_pkg.sv
// Constants for the shared reset pin logic
package srp_pkg;
    // Restart address after a pin reset
    localparam logic [15:0] SRP_RESTART_ADDR = 16'h0000;
    // Power-on window length in clock cycles
    localparam logic [7:0] SRP_POR_CYCLES = 8'h10;
    // Cycle at which the programming-mode request is sampled
    localparam logic [7:0] SRP_ISP_SAMPLE = 8'h0F;
    typedef enum logic [2:0] {
        SRP_POWERON = 3'h1,
        SRP_RUN = 3'h2,
        SRP_HELD = 3'h4
    } srp_state_t;
endpackage

//--- hdl/srp_shared_reset_pin.sv
// Shared reset pin, port 1 bits 3 to 5 pin functions
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Port 1 bit 5 is input only, never driven.
// - Pin is reset input at power-on, later only if configuration selects it.
// - Low on pin while reset active resets ports and peripherals to defaults.
// - After pin reset the processor fetches from address 0.
// - Pin sampled during power-on to request in-system programming mode.
// - Port 1 bit 3 output is open-drain, pulls low only.
// - Port 1 bit 3 also feeds external interrupt zero and I2C data.
// - Port 1 bit 4 is input only and feeds external interrupt one.
module srp_shared_reset_pin
    import srp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic user_config_byte_one,
    input wire logic port1_bit5_in,
    input wire logic port1_bit4_in,
    input wire logic port1_bit3_in,
    input wire logic port1_bit3_latch,
    input wire logic i2c_sda_drive_low,
    output logic port1_bit3_out,
    output logic port1_bit3_oe,
    output logic port1_bit3_value,
    output logic port1_bit4_value,
    output logic port1_bit5_value,
    output logic ext_irq_zero,
    output logic ext_irq_one,
    output logic i2c_sda_in,
    output logic periph_rst_n,
    output logic isp_request,
    output logic [15:0] fetch_addr,
    output logic fetch_addr_load
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    // Reset value matches idle pins, so no false low follows reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
        end else begin
            sync1 <= {port1_bit5_in, port1_bit4_in, port1_bit3_in};
            sync2 <= sync1;
        end
    end
    wire logic pin5 = sync2[2];

    // ------------------------------------------------------------
    // Reset sequencing
    // ------------------------------------------------------------
    srp_state_t state;
    srp_state_t next_state;
    logic [7:0] por_cnt;
    logic [7:0] next_por_cnt;
    logic next_periph_rst_n;
    logic next_isp_request;
    logic next_fetch_addr_load;
    logic reset_active;
    always_comb begin
        next_state = state;
        next_por_cnt = por_cnt;
        next_periph_rst_n = periph_rst_n;
        next_isp_request = isp_request;
        next_fetch_addr_load = 1'h0;
        reset_active = (state == SRP_POWERON) || user_config_byte_one;
        case (state)
            SRP_POWERON: begin
                next_periph_rst_n = 1'h0;
                if (por_cnt == SRP_ISP_SAMPLE) begin
                    next_isp_request = ~pin5;
                end
                // A pin still held low keeps the part in reset
                if (por_cnt == SRP_POR_CYCLES) begin
                    if (pin5) begin
                        next_state = SRP_RUN;
                        next_periph_rst_n = 1'h1;
                        next_fetch_addr_load = 1'h1;
                    end
                end else begin
                    next_por_cnt = por_cnt + 8'h01;
                end
            end
            SRP_RUN: begin
                // low pin resets; ignored when deselected
                if (reset_active && !pin5) begin
                    next_state = SRP_HELD;
                    next_periph_rst_n = 1'h0;
                end
            end
            SRP_HELD: begin
                // Clearing the configuration also ends the hold
                if (pin5 || !reset_active) begin
                    next_state = SRP_RUN;
                    next_periph_rst_n = 1'h1;
                    next_fetch_addr_load = 1'h1;
                end
            end
            default: begin
                next_state = SRP_POWERON;
                next_por_cnt = 8'h00;
            end
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= SRP_POWERON;
            por_cnt <= 8'h00;
            periph_rst_n <= 1'h0;
            isp_request <= 1'h0;
            fetch_addr_load <= 1'h0;
            fetch_addr <= SRP_RESTART_ADDR;
        end else begin
            state <= next_state;
            por_cnt <= next_por_cnt;
            periph_rst_n <= next_periph_rst_n;
            isp_request <= next_isp_request;
            fetch_addr_load <= next_fetch_addr_load;
            fetch_addr <= SRP_RESTART_ADDR;
        end
    end

    // ------------------------------------------------------------
    // Pin functions
    // ------------------------------------------------------------
    // Gated by the registered reset, so oe drops one cycle after it
    logic next_bit3_oe;
    always_comb begin
        // open drain, latch high with no I2C pull-low, or peripheral reset, releases the pin
        next_bit3_oe = periph_rst_n && (!port1_bit3_latch || i2c_sda_drive_low);
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            port1_bit3_out <= 1'h0;
            port1_bit3_oe <= 1'h0;
            port1_bit3_value <= 1'h1;
            port1_bit4_value <= 1'h1;
            port1_bit5_value <= 1'h1;
            ext_irq_zero <= 1'h1;
            ext_irq_one <= 1'h1;
            i2c_sda_in <= 1'h1;
        end else begin
            port1_bit3_out <= 1'h0;
            port1_bit3_oe <= next_bit3_oe;
            port1_bit3_value <= sync2[0];
            ext_irq_zero <= sync2[0];
            i2c_sda_in <= sync2[0];
            port1_bit4_value <= sync2[1];
            ext_irq_one <= sync2[1];
            // bit 5 input only; value always visible
            port1_bit5_value <= pin5;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Pin 3 driver checks
    chk_drain_low_only: assert property (port1_bit3_out == 1'h0)
        else $error("bit 3 drives high");
    chk_pull_when_asked: assert property (
        (periph_rst_n && (!port1_bit3_latch || i2c_sda_drive_low)) |=> port1_bit3_oe)
        else $error("bit 3 not pulled low");
    chk_release_high: assert property (
        (port1_bit3_latch && !i2c_sda_drive_low) |=> !port1_bit3_oe)
        else $error("bit 3 pulled while released");
    chk_reset_frees_pin: assert property (
        !periph_rst_n |=> !port1_bit3_oe)
        else $error("bit 3 pulled during reset");
    // Reset sequencing checks
    chk_held_on_low: assert property (
        (state == SRP_RUN && user_config_byte_one && !pin5) |=> !periph_rst_n)
        else $error("pin low did not reset");
    chk_no_reset_desel: assert property (
        (state == SRP_RUN && !user_config_byte_one) |=> periph_rst_n)
        else $error("reset while deselected");
    chk_held_release: assert property (
        (state == SRP_HELD && (pin5 || !user_config_byte_one)) |=> periph_rst_n)
        else $error("reset not released");
    chk_restart_zero: assert property (
        $rose(periph_rst_n) |-> fetch_addr_load && fetch_addr == SRP_RESTART_ADDR)
        else $error("no restart at zero");
    chk_load_single: assert property (
        fetch_addr_load |=> !fetch_addr_load)
        else $error("restart pulse too long");
    chk_poweron_hold: assert property (
        (state == SRP_POWERON) |-> !periph_rst_n)
        else $error("released during power-on");
    chk_isp_sample: assert property (
        (state == SRP_POWERON && por_cnt == SRP_ISP_SAMPLE) |=> isp_request == !$past(pin5))
        else $error("programming request missampled");
    chk_isp_kept: assert property (
        (state != SRP_POWERON) |=> $stable(isp_request))
        else $error("programming request changed");
    chk_irq_one_track: assert property (
        ##1 ext_irq_one == $past(sync2[1]) && port1_bit4_value == ext_irq_one)
        else $error("bit 4 mismatch");
    chk_irq_zero_track: assert property (
        ##1 ext_irq_zero == $past(sync2[0]) && i2c_sda_in == ext_irq_zero)
        else $error("bit 3 mismatch");
    chk_bit5_visible: assert property (
        ##1 port1_bit5_value == $past(pin5))
        else $error("bit 5 value wrong");
    cov_pin_reset: cover property (state == SRP_RUN ##1 state == SRP_HELD ##[1:20] state == SRP_RUN);
    cov_isp: cover property (isp_request);
    cov_desel_low: cover property (state == SRP_RUN && !user_config_byte_one && !pin5);
    cov_sda_pull: cover property (port1_bit3_oe && i2c_sda_drive_low);
    cov_desel_release: cover property (state == SRP_HELD && !user_config_byte_one);
endmodule
`default_nettype wire

//--- test/srp_board_model.sv
// Board reset circuit and bit 3 wire model
`timescale 1ns/1ps
`default_nettype none
module srp_board_model (
    input wire logic hold_low,
    input wire logic ext3_low,
    input wire logic oe3,
    output logic pin5,
    output logic pin3
);
    assign pin5 = ~hold_low;
    assign pin3 = ~(oe3 | ext3_low);
endmodule
`default_nettype wire

//--- test/shared_reset_pin_logic_tb.sv
// Bench for the shared reset pin logic
`timescale 1ns/1ps
`default_nettype none
module shared_reset_pin_logic_tb;
    import srp_pkg::*;
    logic ref_clk = 1'h0, rst_n = 1'h0, cfg = 1'h1, hold = 1'h1, ext3 = 1'h0, pin4 = 1'h1;
    logic latch3 = 1'h1, sda_low = 1'h0;
    wire pin5, pin3, out3, oe3, v3, v4, v5, irq0, irq1, sda_in, prst_n, isp, load;
    wire [15:0] addr;
    int n_errors = 0, checked = 0;
    always #5 ref_clk = ~ref_clk;
    srp_board_model brd (.hold_low(hold), .ext3_low(ext3), .oe3(oe3), .pin5(pin5),
        .pin3(pin3));
    srp_shared_reset_pin uut (.ref_clk(ref_clk), .rst_n(rst_n), .user_config_byte_one(cfg),
        .port1_bit5_in(pin5), .port1_bit4_in(pin4), .port1_bit3_in(pin3),
        .port1_bit3_latch(latch3), .i2c_sda_drive_low(sda_low), .port1_bit3_out(out3),
        .port1_bit3_oe(oe3), .port1_bit3_value(v3), .port1_bit4_value(v4),
        .port1_bit5_value(v5), .ext_irq_zero(irq0), .ext_irq_one(irq1), .i2c_sda_in(sda_in),
        .periph_rst_n(prst_n), .isp_request(isp), .fetch_addr(addr), .fetch_addr_load(load));
    // ----------------
    // Helpers
    // ----------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic cmp1(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Bounded wait, timeout ends the run
    task automatic wait_rst(input logic v);
        int i;
        for (i = 0; i < 60 && prst_n !== v; i++) cyc(1);
        if (prst_n !== v) begin
            n_errors++;
            $display("ERROR periph_rst_n expected %b seen %b", v, prst_n);
            wrap_up();
        end
    endtask
    task automatic release_pin();
        hold = 1'h0;
        wait_rst(1'h1);
        cmp1("fetch_addr_load", 1'h1, load);
        cmp16("fetch_addr", SRP_RESTART_ADDR, addr);
        cyc(1);
        cmp1("fetch_addr_load", 1'h0, load);
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic power_on_isp();
        cyc(25);
        cmp1("isp_request", 1'h1, isp);
        cmp1("periph_rst_n", 1'h0, prst_n);
        release_pin();
    endtask
    task automatic pin_reset();
        latch3 = 1'h0;
        cyc(2);
        cmp1("port1_bit3_oe", 1'h1, oe3);
        hold = 1'h1;
        wait_rst(1'h0);
        // Oe follows the registered reset one cycle later
        cyc(1);
        cmp1("port1_bit3_oe", 1'h0, oe3);
        latch3 = 1'h1;
        release_pin();
    endtask
    task automatic deselected();
        // Clearing the configuration while held lets the part go
        hold = 1'h1;
        wait_rst(1'h0);
        cfg = 1'h0;
        wait_rst(1'h1);
        cmp1("fetch_addr_load", 1'h1, load);
        cyc(6);
        cmp1("port1_bit5_value", 1'h0, v5);
        repeat (8) begin
            cyc(1);
            cmp1("periph_rst_n", 1'h1, prst_n);
        end
        hold = 1'h0;
        cyc(4);
        cmp1("port1_bit5_value", 1'h1, v5);
        cfg = 1'h1;
    endtask
    task automatic port_bits();
        latch3 = 1'h0;
        cyc(4);
        cmp1("port1_bit3_out", 1'h0, out3);
        cmp1("ext_irq_zero", 1'h0, irq0);
        latch3 = 1'h1;
        sda_low = 1'h1;
        cyc(4);
        cmp1("port1_bit3_oe", 1'h1, oe3);
        cmp1("i2c_sda_in", 1'h0, sda_in);
        sda_low = 1'h0;
        cyc(5);
        cmp1("port1_bit3_value", 1'h1, v3);
        cmp1("i2c_sda_in", 1'h1, sda_in);
        ext3 = 1'h1;
        pin4 = 1'h0;
        cyc(4);
        cmp1("ext_irq_zero", 1'h0, irq0);
        cmp1("ext_irq_one", 1'h0, irq1);
        cmp1("port1_bit4_value", 1'h0, v4);
        ext3 = 1'h0;
        pin4 = 1'h1;
        cyc(4);
        cmp1("ext_irq_one", 1'h1, irq1);
    endtask
    task automatic power_on_plain();
        // Second power-on, pin high, reset function deselected
        rst_n = 1'h0;
        cfg = 1'h0;
        cyc(5);
        cmp1("isp_request", 1'h0, isp);
        cmp1("periph_rst_n", 1'h0, prst_n);
        rst_n = 1'h1;
        cyc(12);
        cmp1("periph_rst_n", 1'h0, prst_n);
        wait_rst(1'h1);
        cmp1("isp_request", 1'h0, isp);
        cmp1("fetch_addr_load", 1'h1, load);
        cfg = 1'h1;
    endtask
    initial begin
        cyc(5);
        rst_n = 1'h1;
        power_on_isp();
        pin_reset();
        deselected();
        port_bits();
        power_on_plain();
        wrap_up();
    end
endmodule
`default_nettype wire
